// *** inc/ppc_pkg.sv ***
package ppc_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [9:0] IDX_P_EDGE_FLAGS = 10'h2F7;
  localparam logic [9:0] IDX_P_OC_GUARD   = 10'h2F9;
  localparam logic [9:0] IDX_P_OC_IRQ_ON  = 10'h2FA;
  localparam logic [9:0] IDX_P_OC_EVENT   = 10'h2FB;
  localparam logic [9:0] IDX_P_WEAK_DRIVE = 10'h2FD;
  localparam logic [9:0] IDX_L_LEVELS     = 10'h331;
  localparam logic [9:0] IDX_L_AUX        = 10'h333;
  localparam logic [9:0] IDX_L_PULL_DIR   = 10'h334;
  localparam logic [9:0] IDX_L_IRQ_ON     = 10'h336;
  localparam logic [9:0] IDX_PULL_ON      = 10'h340;
  localparam logic [9:0] IDX_PULL_DIR     = 10'h341;
  localparam logic [9:0] IDX_OUT_ENABLE   = 10'h342;
  localparam logic [9:0] IDX_OPEN_DRAIN   = 10'h343;
  localparam logic [9:0] IDX_IRQ_STATUS   = 10'h344;
  localparam logic [9:0] IDX_IRQ_CLEAR    = 10'h345;
  localparam logic [9:0] IDX_IRQ_ENABLE   = 10'h346;
  localparam logic [9:0] IDX_L_PULL_ON    = 10'h347;

  // widths
  localparam int ADDR_W  = 12;
  localparam int PORTX_N = 8;
  localparam int PORTP_N = 2;
  localparam int PORTL_N = 3;
  localparam int IRQ_N   = 6;
  localparam int SYNC_N  = PORTX_N + PORTL_N + 1;

  // status layout: port P edges, port L edges, over-current
  localparam int IRQ_P_LSB = 0;
  localparam int IRQ_L_LSB = 2;
  localparam int IRQ_OC    = 5;

  // reset values
  localparam logic [7:0]       RST_BYTE = 8'h00;
  localparam logic [IRQ_N-1:0] RST_IRQ  = 6'h00;
  localparam logic [31:0]      RD_ZERO  = 32'h0000_0000;
endpackage

// *** logic/ppc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // asynchronous levels in, settled levels out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // two flops; only the second stage reads the first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// *** logic/ppc_top.sv ***
// Contract
// - pull-enable bit set turns pin's pull on, cleared turns it off
// - push-pull output pins ignore pull-enable; no pull device active
// - open-drain output pins may only get a pullup, polarity ignored
// - polarity one picks pulldown, zero pullup, only while pull enabled
// - polarity also picks interrupt edge: one rising, zero falling
// - pulldown always goes with rising edge, pullup with falling edge except on open-drain outputs, where polarity one gives pullup and rising
`timescale 1ns/1ps
`default_nettype none
module ppc_top (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // avalon-mm slave
  input  wire logic [ppc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // general port pins
  input  wire logic [ppc_pkg::PORTX_N-1:0] portXLevels,
  output logic      [ppc_pkg::PORTX_N-1:0] portXPullUp,
  output logic      [ppc_pkg::PORTX_N-1:0] portXPullDown,
  // port L input pins
  input  wire logic [ppc_pkg::PORTL_N-1:0] portLLevels,
  output logic      [ppc_pkg::PORTL_N-1:0] portLPullUp,
  output logic      [ppc_pkg::PORTL_N-1:0] portLPullDown,
  output logic      [ppc_pkg::PORTL_N-1:0] portLAuxChoice,
  // port P supply monitor and drive
  input  wire logic                       portPOvercurrent,
  output logic                            portPOvercurrentGuardOn,
  output logic                            portPWeakDrive,
  // interrupt
  output logic                            irq
);
  import ppc_pkg::*;

  logic [7:0]         pullOnBits;
  logic [7:0]         pullDirectionBits;
  logic [7:0]         outEnable;
  logic [7:0]         openDrain;
  logic [7:0]         portLPullOn;
  logic [7:0]         portLPullDirection;
  logic [7:0]         portLAuxReg;
  logic               ocGuardOn;
  logic               weakDrive;
  logic [IRQ_N-1:0]   irqStatus;
  logic [IRQ_N-1:0]   irqEnable;
  logic [IRQ_N-1:0]   next_irqStatus;
  logic [IRQ_N-1:0]   edgeEvents;
  logic [IRQ_N-1:0]   clearBits;
  logic [SYNC_N-1:0]  syncLevels;
  logic [SYNC_N-1:0]  prevLevels;
  logic [PORTX_N-1:0] xLevel;
  logic [PORTX_N-1:0] xPrev;
  logic [PORTL_N-1:0] lLevel;
  logic [PORTL_N-1:0] lPrev;
  logic               ocLevel;
  logic [PORTX_N-1:0] next_xUp;
  logic [PORTX_N-1:0] next_xDown;
  logic [PORTL_N-1:0] next_lUp;
  logic [PORTL_N-1:0] next_lDown;
  logic [9:0]         regIndex;
  logic               busReq;
  logic               wrAccept;
  logic [7:0]         wrByte;
  logic [7:0]         rdByte;

  // pin levels cross into the clock domain first
  ppc_sync #(
    .WIDTH(SYNC_N)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst    (rst),
    .asyncIn({portPOvercurrent, portLLevels, portXLevels}),
    .syncOut(syncLevels)
  );

  assign xLevel  = syncLevels[PORTX_N-1:0];
  assign lLevel  = syncLevels[PORTX_N+PORTL_N-1:PORTX_N];
  assign ocLevel = syncLevels[SYNC_N-1];
  assign xPrev   = prevLevels[PORTX_N-1:0];
  assign lPrev   = prevLevels[PORTX_N+PORTL_N-1:PORTX_N];

  // bus decode; byte registers sit in lane 0
  assign regIndex = avs_address[ADDR_W-1:2];
  assign busReq   = avs_read | avs_write;
  assign wrAccept = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wrByte   = avs_writedata[7:0];

  // one wait state: answer stands in the cycle after the request is seen
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (busReq && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read mux; unmapped and reserved bits read zero
  always_comb begin
    rdByte = RST_BYTE;
    case (regIndex)
      IDX_P_EDGE_FLAGS: rdByte[PORTP_N-1:0] = irqStatus[IRQ_L_LSB-1:IRQ_P_LSB];
      IDX_P_OC_GUARD:   rdByte[0] = ocGuardOn;
      IDX_P_OC_IRQ_ON:  rdByte[0] = irqEnable[IRQ_OC];
      IDX_P_OC_EVENT:   rdByte[0] = irqStatus[IRQ_OC];
      IDX_P_WEAK_DRIVE: rdByte[0] = weakDrive;
      IDX_L_LEVELS:     rdByte[PORTL_N-1:0] = lLevel;
      IDX_L_AUX:        rdByte[PORTL_N-1:0] = portLAuxReg[PORTL_N-1:0];
      IDX_L_PULL_DIR:   rdByte[PORTL_N-1:0] = portLPullDirection[PORTL_N-1:0];
      IDX_L_IRQ_ON:     rdByte[PORTL_N-1:0] = irqEnable[IRQ_OC-1:IRQ_L_LSB];
      IDX_PULL_ON:      rdByte = pullOnBits;
      IDX_PULL_DIR:     rdByte = pullDirectionBits;
      IDX_OUT_ENABLE:   rdByte = outEnable;
      IDX_OPEN_DRAIN:   rdByte = openDrain;
      IDX_IRQ_STATUS:   rdByte[IRQ_N-1:0] = irqStatus;
      IDX_IRQ_ENABLE:   rdByte[IRQ_N-1:0] = irqEnable;
      IDX_L_PULL_ON:    rdByte = portLPullOn;
      default:          rdByte = RST_BYTE;
    endcase
  end

  // read data loaded at the edge that drops waitrequest
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= RD_ZERO;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h000000, rdByte};
    end
  end

  // configuration registers written by software
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pullOnBits         <= RST_BYTE;
      pullDirectionBits  <= RST_BYTE;
      outEnable          <= RST_BYTE;
      openDrain          <= RST_BYTE;
      portLPullOn        <= RST_BYTE;
      portLPullDirection <= RST_BYTE;
      portLAuxReg        <= RST_BYTE;
      ocGuardOn          <= 1'b0;
      weakDrive          <= 1'b0;
    end else if (wrAccept) begin
      case (regIndex)
        IDX_PULL_ON:      pullOnBits         <= wrByte;
        IDX_PULL_DIR:     pullDirectionBits  <= wrByte;
        IDX_OUT_ENABLE:   outEnable          <= wrByte;
        IDX_OPEN_DRAIN:   openDrain          <= wrByte;
        IDX_L_PULL_ON:    portLPullOn        <= wrByte;
        IDX_L_PULL_DIR:   portLPullDirection <= wrByte;
        IDX_L_AUX:        portLAuxReg        <= wrByte;
        IDX_P_OC_GUARD:   ocGuardOn          <= wrByte[0];
        IDX_P_WEAK_DRIVE: weakDrive          <= wrByte[0];
        default:          ocGuardOn          <= ocGuardOn;
      endcase
    end
  end

  // interrupt enables; port L and over-current bytes alias this register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqEnable <= RST_IRQ;
    end else if (wrAccept) begin
      case (regIndex)
        IDX_IRQ_ENABLE:  irqEnable <= wrByte[IRQ_N-1:0];
        IDX_L_IRQ_ON:    irqEnable[IRQ_OC-1:IRQ_L_LSB] <= wrByte[PORTL_N-1:0];
        IDX_P_OC_IRQ_ON: irqEnable[IRQ_OC] <= wrByte[0];
        default:         irqEnable <= irqEnable;
      endcase
    end
  end

  // previous sampled levels for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prevLevels <= '0;
    end else begin
      prevLevels <= syncLevels;
    end
  end

  // per-pin pull control and edge choice
  genvar gi;
  generate
    for (gi = 0; gi < PORTX_N; gi++) begin : g_portx
      always_comb begin
        if (outEnable[gi] && !openDrain[gi]) begin
          next_xUp[gi]   = 1'b0;
          next_xDown[gi] = 1'b0;
        end else if (outEnable[gi]) begin
          next_xUp[gi]   = pullOnBits[gi];
          next_xDown[gi] = 1'b0;
        end else begin
          next_xUp[gi]   = pullOnBits[gi] & ~pullDirectionBits[gi];
          next_xDown[gi] = pullOnBits[gi] & pullDirectionBits[gi];
        end
      end
    end
    for (gi = 0; gi < PORTP_N; gi++) begin : g_portp_edge
      // same bit that picks the pulldown picks the rising edge
      assign edgeEvents[IRQ_P_LSB+gi] = pullDirectionBits[gi] ?
        (xLevel[gi] & ~xPrev[gi]) : (~xLevel[gi] & xPrev[gi]);
    end
    for (gi = 0; gi < PORTL_N; gi++) begin : g_portl
      // port L pins are input only, so pulls follow enable and polarity
      assign next_lUp[gi]   = portLPullOn[gi] & ~portLPullDirection[gi];
      assign next_lDown[gi] = portLPullOn[gi] & portLPullDirection[gi];
      assign edgeEvents[IRQ_L_LSB+gi] = portLPullDirection[gi] ?
        (lLevel[gi] & ~lPrev[gi]) : (~lLevel[gi] & lPrev[gi]);
    end
  endgenerate

  // over-current counts only while the guard is on
  assign edgeEvents[IRQ_OC] = ocGuardOn & ocLevel & ~prevLevels[SYNC_N-1];

  // write-one-to-clear through the clear register or the flag bytes
  always_comb begin
    clearBits = RST_IRQ;
    if (wrAccept) begin
      case (regIndex)
        IDX_IRQ_CLEAR:    clearBits = wrByte[IRQ_N-1:0];
        IDX_P_EDGE_FLAGS: clearBits[IRQ_L_LSB-1:IRQ_P_LSB] = wrByte[PORTP_N-1:0];
        IDX_P_OC_EVENT:   clearBits[IRQ_OC] = wrByte[0];
        default:          clearBits = RST_IRQ;
      endcase
    end
  end

  // a new event in the clear cycle survives: set wins
  assign next_irqStatus = (irqStatus & ~clearBits) | edgeEvents;

  // sticky flags are set regardless of enables
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqStatus <= RST_IRQ;
    end else begin
      irqStatus <= next_irqStatus;
    end
  end

  // request follows the next status so it lines up with the flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irqStatus & irqEnable);
    end
  end

  // registered pin-facing controls
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      portXPullUp             <= '0;
      portXPullDown           <= '0;
      portLPullUp             <= '0;
      portLPullDown           <= '0;
      portLAuxChoice          <= '0;
      portPOvercurrentGuardOn <= 1'b0;
      portPWeakDrive          <= 1'b0;
    end else begin
      portXPullUp             <= next_xUp;
      portXPullDown           <= next_xDown;
      portLPullUp             <= next_lUp;
      portLPullDown           <= next_lDown;
      portLAuxChoice          <= portLAuxReg[PORTL_N-1:0];
      portPOvercurrentGuardOn <= ocGuardOn;
      portPWeakDrive          <= weakDrive;
    end
  end
endmodule
`default_nettype wire

// *** verification/ppc_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppc_top_assertions (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst,
  // register bus
  input wire logic [ppc_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic [3:0]                 avs_byteenable,
  input wire logic                       avs_waitrequest,
  // pins and interrupt
  input wire logic [7:0]                 portXPullUp,
  input wire logic [7:0]                 portXPullDown,
  input wire logic [2:0]                 portLLevels,
  input wire logic [2:0]                 portLPullDown,
  input wire logic                       irq
);
  import ppc_pkg::*;
  logic [7:0] pOn, pDir, oEn, oDr, lOn, lDir, irqEn;
  logic       wDone;
  assign wDone = avs_write & ~avs_waitrequest & avs_byteenable[0];
  // shadow bytes; aliases are not tracked, so only the own indices count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {pOn, pDir, oEn, oDr, lOn, lDir, irqEn} <= 56'h0;
    end else if (wDone) begin
      case (avs_address[11:2])
        IDX_PULL_ON:    pOn <= avs_writedata[7:0];
        IDX_PULL_DIR:   pDir <= avs_writedata[7:0];
        IDX_OUT_ENABLE: oEn <= avs_writedata[7:0];
        IDX_OPEN_DRAIN: oDr <= avs_writedata[7:0];
        IDX_L_PULL_ON:  lOn <= avs_writedata[7:0];
        IDX_L_PULL_DIR: lDir <= avs_writedata[7:0];
        IDX_IRQ_ENABLE: irqEn <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pull_on_off: assert property (
    (portXPullUp | portXPullDown) == $past(pOn & ~(oEn & ~oDr)))
    else $error("pull devices do not follow enable bits");
  a_push_pull_none: assert property (
    ((portXPullUp | portXPullDown) & $past(oEn & ~oDr)) == 8'h00)
    else $error("pull active on push-pull pin");
  a_open_drain_up: assert property (
    ((portXPullDown | (portXPullUp ^ $past(pOn))) & $past(oEn & oDr)) == 8'h00)
    else $error("open-drain pin pull not pullup only");
  a_polarity_pick: assert property (
    portXPullDown == $past(pOn & ~oEn & pDir))
    else $error("pulldown does not follow polarity");
  a_lpull_dir: assert property (
    portLPullDown == $past(lOn[2:0] & lDir[2:0]))
    else $error("port L pulldown does not follow polarity");
  a_edge_irq: assert property (
    |(irqEn[4:2] & ~(lDir[2:0] ^ portLLevels) & (portLLevels ^ $past(portLLevels)))
    |-> ##[2:5] irq)
    else $error("selected edge gave no interrupt");
  a_irq_masked: assert property (
    (irqEn == 8'h00) && ($past(irqEn) == 8'h00) |-> !irq)
    else $error("interrupt with all enables clear");
  a_bus_answer: assert property (
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule
bind ppc_top ppc_top_assertions u_chk (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .portXPullUp, .portXPullDown,
  .portLLevels, .portLPullDown, .irq);
`default_nettype wire

// *** verification/ppc_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppc_board (
  // clock
  input  wire logic       clk,
  // pulls from the block, board drivers
  input  wire logic [7:0] pullUp,
  input  wire logic [7:0] pullDown,
  input  wire logic [7:0] drvOn,
  input  wire logic [7:0] drvLvl,
  // pin levels seen by the block
  output logic      [7:0] pinLevel
);
  logic [7:0] last = 8'h00;
  // a floating pin shows no stale level: it flips every cycle
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drvOn[i]) pinLevel[i] = drvLvl[i];
      else if (pullUp[i] | pullDown[i]) pinLevel[i] = pullUp[i];
      else pinLevel[i] = ~last[i];
    end
  end
  // last level, for the floating case
  always_ff @(posedge clk) begin
    last <= pinLevel;
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ppc_pkg::*;
  logic        ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_waitrequest, irq, portPOvercurrent = 1'b0;
  logic        portPOvercurrentGuardOn, portPWeakDrive;
  logic [7:0]  portXLevels, portXPullUp, portXPullDown, drvOn = 8'hFF, drvLvl = 8'hFF;
  logic [2:0]  portLLevels = 3'h2, portLPullUp, portLPullDown, portLAuxChoice;
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  ppc_top dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .portXLevels, .portXPullUp,
    .portXPullDown, .portLLevels, .portLPullUp, .portLPullDown, .portLAuxChoice,
    .portPOvercurrent, .portPOvercurrentGuardOn, .portPWeakDrive, .irq);
  ppc_board board (.clk(ref_clk), .pullUp(portXPullUp), .pullDown(portXPullDown),
    .drvOn(drvOn), .drvLvl(drvLvl), .pinLevel(portXLevels));
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] a);
    comparisons++;
    if (a !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, a);
    end
  endtask
  // one access; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_read <= ~w;
    avs_write <= w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] q;
    bus(1'b1, i, d, be, q);
    // registered outputs follow one edge after the write lands
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, i, 8'h00, 4'hF, q);
    chk("readdata", {24'h0, e}, q);
  endtask
  task automatic pins(input logic [7:0] up, input logic [7:0] dn);
    chk("portXPullUp", {24'h0, up}, {24'h0, portXPullUp});
    chk("portXPullDown", {24'h0, dn}, {24'h0, portXPullDown});
  endtask
  logic [9:0] zeroIdx [8] = '{IDX_PULL_ON, IDX_PULL_DIR, IDX_OUT_ENABLE, IDX_OPEN_DRAIN,
    IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_L_PULL_DIR, 10'h300};
  initial begin
    repeat (20) @(posedge ref_clk);
    chk("waitrequest", 32'h1, {31'h0, avs_waitrequest});
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (zeroIdx[k]) rd(zeroIdx[k], 8'h00);
    rd(IDX_L_LEVELS, 8'h02);
    // pulls on inputs, then partly disabled
    wr(IDX_PULL_ON, 8'hFF);
    wr(IDX_PULL_DIR, 8'hF0);
    pins(8'h0F, 8'hF0);
    wr(IDX_PULL_ON, 8'h3C);
    pins(8'h0C, 8'h30);
    // mix of inputs, open-drain and push-pull outputs
    wr(IDX_OUT_ENABLE, 8'hCC);
    wr(IDX_OPEN_DRAIN, 8'hA0);
    wr(IDX_PULL_ON, 8'hFF);
    pins(8'h83, 8'h30);
    rd(IDX_OPEN_DRAIN, 8'hA0);
    // floating port P pins follow their pulls; that edge is never the selected one
    drvOn <= 8'h00;
    wr(IDX_PULL_DIR, 8'hF1);
    repeat (4) @(posedge ref_clk);
    wr(IDX_PULL_DIR, 8'hF0);
    repeat (4) @(posedge ref_clk);
    rd(IDX_IRQ_STATUS, 8'h00);
    drvOn <= 8'hFF;
    wr(IDX_L_PULL_ON, 8'h07);
    wr(IDX_L_PULL_DIR, 8'h05);
    chk("portLPullDown", 32'h5, {29'h0, portLPullDown});
    chk("portLPullUp", 32'h2, {29'h0, portLPullUp});
    // selected edges flag, disabled events raise no interrupt
    portLLevels <= 3'h5;
    repeat (6) @(posedge ref_clk);
    rd(IDX_IRQ_STATUS, 8'h1C);
    chk("irq", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_CLEAR, 8'h3F);
    portLLevels <= 3'h2;
    repeat (6) @(posedge ref_clk);
    rd(IDX_IRQ_STATUS, 8'h00);
    wr(IDX_IRQ_ENABLE, 8'h08);
    portLLevels <= 3'h0;
    repeat (6) @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(IDX_IRQ_ENABLE, 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    wr(IDX_IRQ_ENABLE, 8'h08);
    wr(IDX_IRQ_CLEAR, 8'h08);
    chk("irq", 32'h0, {31'h0, irq});
    // port P pin 0 falls under pullup polarity: flagged, cleared through its own byte
    drvLvl <= 8'hFE;
    repeat (6) @(posedge ref_clk);
    rd(IDX_P_EDGE_FLAGS, 8'h01);
    wr(IDX_P_EDGE_FLAGS, 8'h01);
    rd(IDX_IRQ_STATUS, 8'h00);
    // guard, over-current event, drive and aux copies
    wr(IDX_P_OC_GUARD, 8'h01, 4'h0);
    chk("guardOn", 32'h0, {31'h0, portPOvercurrentGuardOn});
    wr(IDX_P_OC_GUARD, 8'h01);
    chk("guardOn", 32'h1, {31'h0, portPOvercurrentGuardOn});
    portPOvercurrent <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(IDX_P_OC_EVENT, 8'h01);
    // over-current enable through its alias byte raises the request
    wr(IDX_P_OC_IRQ_ON, 8'h01);
    chk("irq", 32'h1, {31'h0, irq});
    rd(IDX_IRQ_ENABLE, 8'h28);
    wr(IDX_P_WEAK_DRIVE, 8'h01);
    wr(IDX_L_AUX, 8'h05);
    chk("weakDrive", 32'h1, {31'h0, portPWeakDrive});
    chk("auxChoice", 32'h5, {29'h0, portLAuxChoice});
    close_out();
  end
endmodule
`default_nettype wire
